// ===== inc/sbg_pkg.sv
/*
 * sbg_pkg: register map, field positions, reset values and divide
 * constants of the secondary serial port baud rate generator.
 * Assumes a plain register port with one-cycle strobes.
 */
package sbg_pkg;
    // register offsets on the plain register port
    localparam logic [1:0] TX_CTRL_OFS   = 2'h0;
    localparam logic [1:0] RX_CTRL_OFS   = 2'h1;
    localparam logic [1:0] DIVISOR_OFS   = 2'h2;
    // transmit control/status field positions
    localparam int TX_MASTER_BIT  = 7;
    localparam int TX_NINE_BIT    = 6;
    localparam int TX_ENABLE_BIT  = 5;
    localparam int TX_SYNC_BIT    = 4;
    localparam int TX_FAST_BIT    = 2;
    localparam int TX_EMPTY_BIT   = 1;
    localparam int TX_D9_BIT      = 0;
    // receive control/status field positions
    localparam int RX_PORT_EN_BIT = 7;
    localparam int RX_VOTE_BIT    = 0;
    // implemented bits: bit 3 of transmit control is unimplemented
    localparam logic [7:0] TX_WRITE_MASK = 8'hF5;
    localparam logic [7:0] RX_WRITE_MASK = 8'hF8;
    // reset values
    localparam logic [7:0] TX_CTRL_RST   = 8'h02;
    localparam logic [7:0] RX_CTRL_RST   = 8'h00;
    localparam logic [7:0] DIVISOR_RST   = 8'h00;
    // prescale: device clocks per divisor step (sub-tick) in each mode
    localparam logic [5:0] PRE_ASYNC_SLOW = 6'h3F; // 64 clocks
    localparam logic [5:0] PRE_ASYNC_FAST = 6'h0F; // 16 clocks
    localparam logic [5:0] PRE_SYNC       = 6'h03; // 4 clocks
    // modes decoded from the transmit sync and fast bits
    typedef enum logic [1:0] {
        SBG_MODE_ASYNC_SLOW = 2'b00,
        SBG_MODE_ASYNC_FAST = 2'b01,
        SBG_MODE_SYNC       = 2'b10
    } sbg_mode_t;
endpackage

// ===== rtl/sbg_vote.sv
/*
 * sbg_vote: three-sample majority detector for the receive input.
 * Assumes sample strobes come from the generator's sub-bit ticks.
 */
`timescale 1ns/1ns
module sbg_vote (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic sampleStb,
    input  wire logic lastStb,
    input  wire logic rxIn,
    output logic      level
);
    logic [1:0] samp_reg;

    // shift in one sample per strobe; two are kept, the third is the
    // pin itself at the last strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            samp_reg <= 2'h3;
        end else if (sampleStb) begin
            samp_reg <= {samp_reg[0], rxIn};
        end
    end

    // majority of the three; idle line is high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level <= 1'b1;
        end else if (lastStb) begin
            level <= (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & rxIn)
                   | (samp_reg[1] & rxIn);
        end
    end
endmodule

// ===== rtl/sbg_top.sv
/*
 * sbg_top: baud rate generator of the secondary serial port, with
 * its control/status registers and receive majority sampler.
 * Assumes clk is the currently selected device clock and rxPin is
 * synchronous to it; software uses the plain register port.
 * Only the generator and the majority sampler live here; the shift
 * paths that consume bitTick and subTick sit outside this block.
 * Changing the mode bits without a divisor write bends the current
 * bit period once; software should always rewrite the divisor.
 */
//   Function
// - bit timing runs off the device clock
// - receive level is a three-sample majority
// - rate is clk/64, /16 or /4 times n+1
// - unimplemented bits read as zero
// - free-running timer with 8-bit divisor
// - sync ignores fast bit; master mode only
// - divisor write clears the timer at once
`timescale 1ns/1ns
module sbg_top
    import sbg_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStb,
    input  wire logic       rdStb,
    output logic      [7:0] rdData,
    input  wire logic       rxPin,
    output logic            bitTick,
    output logic            subTick,
    output logic            rxLevel,
    output logic            rxLevelValid
);
    import sbg_pkg::*;

    logic [7:0]       txCtrl_reg;
    logic [7:0]       rxCtrl_reg;
    logic [DIV_W-1:0] divisor_reg;
    logic [DIV_W-1:0] divCnt_reg;
    logic [5:0]       preCnt_reg;
    logic [5:0]       preTop;
    logic             divWrite;
    logic             preWrap;
    logic             runGen;
    logic             voteStb;
    logic             voteLast;
    logic             voteLevel;
    logic             genStep;
    logic             divLast;
    sbg_mode_t        mode;

    // mode decode used only by the prescale top; sample placement
    // counts divisor steps and does not depend on the mode
    function automatic sbg_mode_t modeOf(input logic [7:0] tx);
        if (tx[TX_SYNC_BIT]) begin
            return SBG_MODE_SYNC; // fast bit ignored
        end else if (tx[TX_FAST_BIT]) begin
            return SBG_MODE_ASYNC_FAST;
        end
        return SBG_MODE_ASYNC_SLOW;
    endfunction

    assign mode     = modeOf(txCtrl_reg);
    assign divWrite = wrStb && (addr == DIVISOR_OFS);
    // in sync slave mode the clock comes from outside
    assign runGen   = rxCtrl_reg[RX_PORT_EN_BIT]
                   && (!txCtrl_reg[TX_SYNC_BIT]
                       || txCtrl_reg[TX_MASTER_BIT]);

    // prescale top per mode
    always_comb begin
        case (mode)
            SBG_MODE_ASYNC_SLOW: preTop = PRE_ASYNC_SLOW;
            SBG_MODE_ASYNC_FAST: preTop = PRE_ASYNC_FAST;
            SBG_MODE_SYNC:       preTop = PRE_SYNC;
            default:             preTop = PRE_ASYNC_SLOW;
        endcase
    end
    // a mode change can leave the count above the new top; >= folds
    // it back at once instead of running on to the 6-bit wrap
    assign preWrap = (preCnt_reg >= preTop);

    // one divisor step ends; a divisor write wins so that no stale
    // tick escapes in the cycle the counters are cleared
    assign genStep = runGen && !divWrite && preWrap;
    // last divisor step of the bit period
    assign divLast = (divCnt_reg == divisor_reg);

    // transmit control; empty flag is status, bit 3 is not stored
    // the empty flag belongs to the transmitter outside, so a write
    // keeps whatever it holds
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txCtrl_reg <= TX_CTRL_RST;
        end else if (wrStb && addr == TX_CTRL_OFS) begin
            txCtrl_reg <= (wrData & TX_WRITE_MASK & ~(8'h02))
                        | (txCtrl_reg & 8'h02);
        end
    end

    // receive control; low bits are status from the receiver
    // bit 0 shows the last voted level; bits 2:1 have no source here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxCtrl_reg <= RX_CTRL_RST;
        end else begin
            if (wrStb && addr == RX_CTRL_OFS) begin
                rxCtrl_reg[7:3] <= wrData[7:3];
            end
            rxCtrl_reg[2:1] <= 2'h0;
            rxCtrl_reg[RX_VOTE_BIT] <= voteLevel; // resolved level
        end
    end

    // divisor register; software rewrites it after a clock source
    // change, and every write restarts the bit period
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divisor_reg <= DIV_W'(DIVISOR_RST);
        end else if (divWrite) begin
            divisor_reg <= wrData[DIV_W-1:0];
        end
    end

    // prescaler: 64, 16 or 4 device clocks per divisor step
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preCnt_reg <= 6'h00;
        end else if (divWrite || !runGen || preWrap) begin
            preCnt_reg <= 6'h00; // divisor write clears timer
        end else begin
            preCnt_reg <= preCnt_reg + 6'h01;
        end
    end

    // free-running divisor counter, n+1 prescale periods
    // n = 0 gives one prescale period per bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt_reg <= '0;
        end else if (divWrite || !runGen) begin
            divCnt_reg <= '0;
        end else if (preWrap) begin
            if (divLast) begin
                divCnt_reg <= '0;
            end else begin
                divCnt_reg <= divCnt_reg + DIV_W'(1);
            end
        end
    end

    // bit and sub-bit ticks, registered registering costs a
    // cycle of latency but keeps glitches off the outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bitTick <= 1'b0;
            subTick <= 1'b0;
        end else begin
            bitTick <= genStep && divLast;
            subTick <= genStep;
        end
    end

    // samples at divisor steps n/2-1, n/2, n/2+1 (mid bit); with a
    // small divisor the three collapse onto fewer steps, so sampling
    // then spreads only over what exists the spacing is one
    // prescale period, so noise shorter than that is outvoted
    always_comb begin
        logic [DIV_W-1:0] mid;
        mid      = divisor_reg >> 1;
        voteStb  = 1'b0;
        voteLast = 1'b0;
        if (genStep) begin
            voteStb  = (divCnt_reg + DIV_W'(1) == mid)
                    || (divCnt_reg == mid)
                    || (divCnt_reg == mid + DIV_W'(1));
            voteLast = (divCnt_reg == mid + DIV_W'(1))
                    || (divisor_reg < DIV_W'(2) && divCnt_reg == mid);
        end
    end

    // the sampler reads the pin as is; it is taken as synchronous
    sbg_vote u_vote (
        .clk       (clk),
        .rstn      (rstn),
        .sampleStb (voteStb),
        .lastStb   (voteLast),
        .rxIn      (rxPin),
        .level     (voteLevel)
    );

    // resolved level and its valid pulse
    // delayed a cycle so both leave the block from flip-flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxLevel      <= 1'b1;
            rxLevelValid <= 1'b0;
        end else begin
            rxLevel      <= voteLevel;
            rxLevelValid <= voteLast;
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= 8'h00;
        end else if (rdStb) begin
            case (addr)
                // bit 3 is never stored, so it reads as zero
                TX_CTRL_OFS: rdData <= txCtrl_reg;
                RX_CTRL_OFS: rdData <= rxCtrl_reg;
                DIVISOR_OFS: rdData <= 8'(divisor_reg);
                default:     rdData <= 8'h00;
            endcase
        end else begin
            // zero between reads, so a stale value is never taken
            rdData <= 8'h00;
        end
    end
endmodule

// ===== tb/sbg_chk.sv
/* sbg_chk: port assertions for sbg_top.
   Assumes a bind onto sbg_top and the single clk domain. */
`timescale 1ns/1ns
module sbg_chk
    import sbg_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [1:0] addr,
    input wire logic [7:0] wrData,
    input wire logic       wrStb,
    input wire logic       rdStb,
    input wire logic [7:0] rdData,
    input wire logic       rxPin,
    input wire logic       bitTick,
    input wire logic       subTick,
    input wire logic       rxLevel,
    input wire logic       rxLevelValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // read data only stands right after a strobe
    a_rd_after_stb:
        assert property (rdData != 8'h00 |-> $past(rdStb))
        else $error("read data without a strobe");
    a_unmapped_zero:
        assert property (rdStb && addr == 2'h3 |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    a_tx_gap_zero:
        assert property (rdStb && addr == TX_CTRL_OFS |=> !rdData[3])
        else $error("unimplemented transmit bit set");
    a_rx_gap_zero:
        assert property (rdStb && addr == RX_CTRL_OFS |=> rdData[2:1] == 0)
        else $error("unimplemented receive bits set");
    // divisor written, then read two cycles on
    a_div_readback:
        assert property (wrStb && addr == DIVISOR_OFS ##1 !wrStb ##1
            rdStb && addr == DIVISOR_OFS |=> rdData == $past(wrData, 3))
        else $error("divisor read back wrong");
    // old count must not leak past the clear; the fastest step
    // needs four clocks after it
    a_div_clear:
        assert property (wrStb && addr == DIVISOR_OFS |=>
            (!bitTick && !subTick) [*4])
        else $error("tick soon after divisor write");
    a_level_cause:
        assert property ($changed(rxLevel) |-> $past(rxLevelValid))
        else $error("level moved without a vote");
    a_valid_pulse:
        assert property (rxLevelValid |=> !rxLevelValid)
        else $error("vote strobe longer than a cycle");
endmodule

// ===== tb/tb_top.sv
/* tb_top: self-checking bench for sbg_top.
   Assumes a 125 MHz clk and the register map of sbg_pkg. */
`timescale 1ns/1ns
module tb_top;
    import sbg_pkg::*;
    localparam int LIMIT = 2000;
    logic       clk    = 1'b0;
    logic       rstn   = 1'b0;
    logic       wrStb  = 1'b0;
    logic       rdStb  = 1'b0;
    logic       rxPin  = 1'b1;
    logic [1:0] addr   = 2'h0;
    logic [7:0] wrData = 8'h00;
    logic [7:0] rdData;
    logic       bitTick, subTick, rxLevel, rxLevelValid;
    int         error_cnt = 0, tests_run = 0, cycles = 0;

    sbg_top #(.DIV_W(8)) i_sbg_top (.clk(clk), .rstn(rstn), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
        .rxPin(rxPin), .bitTick(bitTick), .subTick(subTick),
        .rxLevel(rxLevel), .rxLevelValid(rxLevelValid));

    // 8 ns period
    always #4 clk = ~clk;
    // hang guard, well above the slowest run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    // masked read; the data stand only in the cycle after the strobe
    task automatic rdchk(input logic [1:0] a, input logic [7:0] m, e);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 check({8'h00, rdData & m}, {8'h00, e});
    endtask
    // counts cycles to the next bit tick, LIMIT if none
    task automatic waitTick(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1 c++;
        end while (bitTick !== 1'b1 && c < LIMIT);
    endtask
    task automatic t_regs;
        rdchk(TX_CTRL_OFS, 8'hFF, TX_CTRL_RST);
        rdchk(RX_CTRL_OFS, 8'hFE, RX_CTRL_RST);
        rdchk(DIVISOR_OFS, 8'hFF, DIVISOR_RST);
        wr(TX_CTRL_OFS, 8'hFF);
        wr(2'h3, 8'hFF);
        rdchk(TX_CTRL_OFS, 8'hFF, TX_WRITE_MASK | 8'h02);
        wr(RX_CTRL_OFS, 8'hFF);
        rdchk(RX_CTRL_OFS, 8'hFE, 8'hF8);
        rdchk(2'h3, 8'hFF, 8'h00);
        wr(DIVISOR_OFS, 8'hA5);
        rdchk(DIVISOR_OFS, 8'hFF, 8'hA5);
        $display("register test done");
    endtask
    task automatic t_rate(input logic [7:0] tx, input int p, n);
        int c;
        wr(TX_CTRL_OFS, tx);
        wr(DIVISOR_OFS, 8'(n));
        waitTick(c);
        check(16'(c >= p * (n + 1) && c <= p * (n + 1) + 1), 16'h1);
        waitTick(c);
        check(16'(c), 16'(p * (n + 1)));
        check(16'(subTick), 16'h1);
        c = 0;
        do begin
            @(posedge clk);
            #1 c++;
        end while (subTick !== 1'b1 && c < LIMIT);
        check(16'(c), 16'(p));
        $display("rate test done, mode %h", tx);
    endtask
    // slave sync and a disabled port must both stop the generator
    task automatic t_gate;
        int c;
        wr(TX_CTRL_OFS, 8'h10);
        wr(DIVISOR_OFS, 8'h00);
        waitTick(c);
        check(16'(c), 16'(LIMIT));
        wr(TX_CTRL_OFS, 8'h90);
        wr(RX_CTRL_OFS, 8'h00);
        waitTick(c);
        check(16'(c), 16'(LIMIT));
        wr(RX_CTRL_OFS, 8'h80);
        $display("gating test done");
    endtask
    // second vote is wholly after the change
    task automatic t_vote(input logic lvl);
        int c;
        @(posedge clk);
        rxPin <= lvl;
        repeat (2) begin
            c = 0;
            @(posedge clk);
            #1 while (rxLevelValid !== 1'b1 && c < LIMIT) begin
                @(posedge clk);
                #1 c++;
            end
            check(16'(c < LIMIT), 16'h1);
        end
        @(posedge clk);
        #1 check(16'(rxLevel), 16'(lvl));
        rdchk(RX_CTRL_OFS, 8'h01, {7'h00, lvl});
        $display("vote test done, level %0d", lvl);
    endtask
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_rate(8'h00, 64, 3);
        t_rate(8'h04, 16, 7);
        t_rate(8'h94, 4, 0);
        t_rate(8'h90, 4, 255);
        t_gate();
        wr(DIVISOR_OFS, 8'h03);
        t_vote(1'b0);
        t_vote(1'b1);
        conclude();
    end
endmodule
bind sbg_top sbg_chk #(.DIV_W(DIV_W)) i_sbg_chk (.clk(clk), .rstn(rstn),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .rxPin(rxPin), .bitTick(bitTick), .subTick(subTick),
    .rxLevel(rxLevel), .rxLevelValid(rxLevelValid));
